// >>> hw/pvc_regs.sv
// voltage code register bank with serial slave, enable edge and fault pin
//
// Function
// - buck codes 00h-0Fh: 0.800 V plus 25 mV
// - buck codes 10h-1Ch: 1.200 V plus 50 mV
// - buck at 02h; code 1Ch gives 1.800 V
// - linear regulators at 03h, 04h, shared lookup
// - linear lookup: sparse codes, 0.8-3.3 V, 50 mV
// - startup only on enable rising edge
// - open-drain fault pin from undervoltage, thermal flags
// - fault pin asserts with flag when enabled
// - clock up to 400 kHz; data pin bidirectional
// - only three low register address bits decoded
// - write: address, register byte, data byte
// - answer bus address 1011010, read/write bit last
// - status gate bit enables fault pin output
`timescale 1ns/100ps
`default_nettype none

module pvc_regs
  import pvc_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic scl_i,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe_o,
  input wire logic enable_pin_i,
  input wire logic input_undervoltage_flag_i,
  input wire logic thermal_shutdown_flag_i,
  input wire logic [2:0] rail_valid_i,
  output logic fault_interrupt_n_o,
  output logic fault_interrupt_oe_o,
  output logic startup_pulse_o,
  output logic [7:0] enable_ctrl_o,
  output logic [15:0] buck_mv_o,
  output logic [15:0] linear_one_mv_o,
  output logic [15:0] linear_two_mv_o
);

  ////////////////////////////////////////////////////////////////////////////
  // input synchronisers

  logic [PVC_IN_W-1:0] in_raw;
  logic [PVC_IN_W-1:0] in_meta_r;
  logic [PVC_IN_W-1:0] in_sync_r;
  logic [PVC_IN_W-1:0] in_prev_r;

  assign in_raw = {rail_valid_i, thermal_shutdown_flag_i,
                   input_undervoltage_flag_i, enable_pin_i, sda_i, scl_i};

  // two-stage sampling: 20 MHz oversamples the serial pins
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      in_meta_r <= 8'h03;
      in_sync_r <= 8'h03;
      in_prev_r <= 8'h03;
    end else begin
      in_meta_r <= in_raw;
      in_sync_r <= in_meta_r;
      in_prev_r <= in_sync_r;
    end
  end

  logic scl;
  logic sda;
  logic scl_rise;
  logic scl_fall;
  logic bus_start;
  logic bus_stop;
  logic en_rise;

  assign scl = in_sync_r[PVC_IN_SCL];
  assign sda = in_sync_r[PVC_IN_SDA];
  assign scl_rise = scl & ~in_prev_r[PVC_IN_SCL];
  assign scl_fall = ~scl & in_prev_r[PVC_IN_SCL];
  assign bus_start = scl & in_prev_r[PVC_IN_SCL] & ~sda & in_prev_r[PVC_IN_SDA];
  assign bus_stop = scl & in_prev_r[PVC_IN_SCL] & sda & ~in_prev_r[PVC_IN_SDA];
  assign en_rise = in_sync_r[PVC_IN_EN] & ~in_prev_r[PVC_IN_EN];

  ////////////////////////////////////////////////////////////////////////////
  // register read mux

  logic [7:0] enable_r;
  logic int_en_r;
  logic uv_r;
  logic therm_r;
  logic [7:0] buck_r;
  logic [7:0] lin1_r;
  logic [7:0] lin2_r;

  function automatic logic [7:0] rd_mux(input logic [2:0] idx,
                                        input logic [7:0] st);
    case (idx)
      PVC_IDX_ENABLE: rd_mux = enable_r;
      PVC_IDX_STATUS: rd_mux = st;
      PVC_IDX_BUCK: rd_mux = buck_r;
      PVC_IDX_LIN1: rd_mux = lin1_r;
      PVC_IDX_LIN2: rd_mux = lin2_r;
      default: rd_mux = 8'h00;
    endcase
  endfunction

  logic [7:0] status_val;

  // status layout: gate, sticky flags, live rail valid bits
  always_comb begin
    status_val = 8'h00;
    status_val[PVC_ST_INT_EN] = int_en_r;
    status_val[PVC_ST_UV] = uv_r;
    status_val[PVC_ST_THERM] = therm_r;
    status_val[2:0] = in_sync_r[PVC_IN_VALID +: 3];
  end

  ////////////////////////////////////////////////////////////////////////////
  // serial slave

  pvc_i2c_e state_r, state_nxt;
  logic [3:0] cnt_r, cnt_nxt;
  logic [7:0] shreg_r, shreg_nxt;
  logic [2:0] ptr_r, ptr_nxt;
  logic oe_r, oe_nxt;
  logic sda_n_r;
  logic rw_r, rw_nxt;
  pvc_wr_s wr;

  // bit engine: start/stop first, then clock edges
  always_comb begin
    state_nxt = state_r;
    cnt_nxt = cnt_r;
    shreg_nxt = shreg_r;
    ptr_nxt = ptr_r;
    oe_nxt = oe_r;
    rw_nxt = rw_r;
    wr = '0;
    if (bus_start) begin
      state_nxt = PVC_ADDR;
      cnt_nxt = 4'h0;
      oe_nxt = 1'b0;
    end else if (bus_stop) begin
      state_nxt = PVC_IDLE;
      oe_nxt = 1'b0;
    end else if (scl_rise) begin
      case (state_r)
        PVC_ADDR, PVC_REG, PVC_WDATA: begin
          shreg_nxt = {shreg_r[6:0], sda};
          cnt_nxt = 4'(cnt_r + 4'h1);
        end
        PVC_RACK: begin
          if (sda) begin
            state_nxt = PVC_IDLE; // master ends the read
          end else begin
            ptr_nxt = 3'(ptr_r + 3'h1);
          end
        end
        default: ;
      endcase
    end else if (scl_fall) begin
      case (state_r)
        PVC_ADDR: begin
          if (cnt_r == 4'h8) begin
            // match seven-bit address, keep direction bit
            if (shreg_r[7:1] == PVC_DEV_ADDR) begin
              rw_nxt = shreg_r[0];
              oe_nxt = 1'b1;
              state_nxt = PVC_ACK_ADDR;
            end else begin
              state_nxt = PVC_IDLE;
            end
          end
        end
        PVC_REG: begin
          if (cnt_r == 4'h8) begin
            ptr_nxt = shreg_r[2:0];
            oe_nxt = 1'b1;
            state_nxt = PVC_ACK_REG;
          end
        end
        PVC_WDATA: begin
          if (cnt_r == 4'h8) begin
            // data byte lands in selected register
            wr.en = 1'b1;
            wr.idx = ptr_r;
            wr.data = shreg_r;
            ptr_nxt = 3'(ptr_r + 3'h1);
            oe_nxt = 1'b1;
            state_nxt = PVC_ACK_DATA;
          end
        end
        PVC_ACK_ADDR: begin
          cnt_nxt = 4'h0;
          if (rw_r) begin
            shreg_nxt = rd_mux(ptr_r, status_val);
            oe_nxt = ~shreg_nxt[7];
            state_nxt = PVC_RDATA;
          end else begin
            oe_nxt = 1'b0;
            state_nxt = PVC_REG;
          end
        end
        PVC_ACK_REG, PVC_ACK_DATA: begin
          cnt_nxt = 4'h0;
          oe_nxt = 1'b0;
          state_nxt = PVC_WDATA;
        end
        PVC_RDATA: begin
          // readback driven on the data pin
          if (cnt_r == 4'h7) begin
            oe_nxt = 1'b0;
            cnt_nxt = 4'h0;
            state_nxt = PVC_RACK;
          end else begin
            shreg_nxt = {shreg_r[6:0], 1'b0};
            oe_nxt = ~shreg_r[6];
            cnt_nxt = 4'(cnt_r + 4'h1);
          end
        end
        PVC_RACK: begin
          shreg_nxt = rd_mux(ptr_r, status_val);
          oe_nxt = ~shreg_nxt[7];
          state_nxt = PVC_RDATA;
        end
        default: ;
      endcase
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state_r <= PVC_IDLE;
      cnt_r <= 4'h0;
      shreg_r <= 8'h00;
      ptr_r <= 3'h0;
      oe_r <= 1'b0;
      sda_n_r <= 1'b1;
      rw_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      cnt_r <= cnt_nxt;
      shreg_r <= shreg_nxt;
      ptr_r <= ptr_nxt;
      oe_r <= oe_nxt;
      sda_n_r <= ~oe_nxt;
      rw_r <= rw_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // register file

  logic [7:0] enable_nxt;
  logic int_en_nxt;
  logic uv_nxt;
  logic therm_nxt;
  logic [7:0] buck_nxt;
  logic [7:0] lin1_nxt;
  logic [7:0] lin2_nxt;
  logic st_wr;
  logic irq_nxt;
  logic irq_r;
  logic irq_n_r;
  logic start_r;
  logic [15:0] buck_mv_nxt;
  logic [15:0] buck_mv_r;

  // writes, echo-reset flags (set wins), enable defaults on edge
  always_comb begin
    enable_nxt = enable_r;
    int_en_nxt = int_en_r;
    buck_nxt = buck_r;
    lin1_nxt = lin1_r;
    lin2_nxt = lin2_r;
    st_wr = wr.en && (wr.idx == PVC_IDX_STATUS);
    if (wr.en) begin
      case (wr.idx)
        PVC_IDX_ENABLE: enable_nxt = wr.data & PVC_EN_WMASK;
        PVC_IDX_STATUS: int_en_nxt = wr.data[PVC_ST_INT_EN];
        PVC_IDX_BUCK: buck_nxt = wr.data;
        PVC_IDX_LIN1: lin1_nxt = wr.data;
        PVC_IDX_LIN2: lin2_nxt = wr.data;
        default: ;
      endcase
    end
    if (en_rise) begin
      enable_nxt = PVC_EN_STARTUP;
    end
    uv_nxt = in_sync_r[PVC_IN_UV] |
             (uv_r & ~(st_wr & wr.data[PVC_ST_UV]));
    therm_nxt = in_sync_r[PVC_IN_THERM] |
                (therm_r & ~(st_wr & wr.data[PVC_ST_THERM]));
    // pin follows the flag's next value
    irq_nxt = int_en_nxt & (uv_nxt | therm_nxt);
    // codes above the table clamp to the top
    if (buck_r <= PVC_BUCK_FINE_LAST) begin
      buck_mv_nxt = 16'(PVC_BUCK_FINE_BASE_MV +
                        PVC_BUCK_FINE_STEP_MV * {8'h00, buck_r});
    end else if (buck_r <= PVC_BUCK_MAX_CODE) begin
      buck_mv_nxt = 16'(PVC_BUCK_COARSE_BASE_MV + PVC_BUCK_COARSE_STEP_MV *
                        {8'h00, 8'(buck_r - PVC_BUCK_COARSE_FIRST)});
    end else begin
      buck_mv_nxt = PVC_BUCK_MAX_MV;
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      enable_r <= PVC_EN_POR;
      int_en_r <= 1'b0;
      uv_r <= 1'b0;
      therm_r <= 1'b0;
      buck_r <= PVC_BUCK_RST;
      lin1_r <= PVC_LIN1_RST;
      lin2_r <= PVC_LIN2_RST;
      irq_r <= 1'b0;
      irq_n_r <= 1'b1;
      start_r <= 1'b0;
      buck_mv_r <= PVC_BUCK_COARSE_BASE_MV;
    end else begin
      enable_r <= enable_nxt;
      int_en_r <= int_en_nxt;
      uv_r <= uv_nxt;
      therm_r <= therm_nxt;
      buck_r <= buck_nxt;
      lin1_r <= lin1_nxt;
      lin2_r <= lin2_nxt;
      irq_r <= irq_nxt;
      irq_n_r <= ~irq_nxt;
      start_r <= en_rise;
      buck_mv_r <= buck_mv_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // linear regulator lookups and outputs

  // shared sparse-code lookup, one per regulator
  pvc_lin_lut u_lut_one (
    .clk_i(clk_i),
    .rst_n_i(rst_n_i),
    .code_i(lin1_r),
    .mv_o(linear_one_mv_o)
  );

  pvc_lin_lut u_lut_two (
    .clk_i(clk_i),
    .rst_n_i(rst_n_i),
    .code_i(lin2_r),
    .mv_o(linear_two_mv_o)
  );

  // pin values registered apart from their enables, no gate on the path
  assign sda_o = sda_n_r;
  assign sda_oe_o = oe_r;
  assign fault_interrupt_n_o = irq_n_r;
  assign fault_interrupt_oe_o = irq_r;
  assign startup_pulse_o = start_r;
  assign enable_ctrl_o = enable_r;
  assign buck_mv_o = buck_mv_r;

endmodule

`default_nettype wire

// >>> hw/pvc_pkg.sv
// package: constants, types and tables of the voltage code register bank
package pvc_pkg;

  // serial bus address and register indices (low three address bits)
  localparam logic [6:0] PVC_DEV_ADDR = 7'h5A;
  localparam logic [2:0] PVC_IDX_ENABLE = 3'h0;
  localparam logic [2:0] PVC_IDX_STATUS = 3'h1;
  localparam logic [2:0] PVC_IDX_BUCK = 3'h2;
  localparam logic [2:0] PVC_IDX_LIN1 = 3'h3;
  localparam logic [2:0] PVC_IDX_LIN2 = 3'h4;

  // enable register: power-on value, default-startup value, writable bits
  localparam logic [7:0] PVC_EN_POR = 8'h20;
  localparam logic [7:0] PVC_EN_STARTUP = 8'h27;
  localparam logic [7:0] PVC_EN_WMASK = 8'h37;

  // status register field positions
  localparam int PVC_ST_INT_EN = 6;
  localparam int PVC_ST_UV = 5;
  localparam int PVC_ST_THERM = 4;

  // voltage code registers after reset
  localparam logic [7:0] PVC_BUCK_RST = 8'h10;
  localparam logic [7:0] PVC_LIN1_RST = 8'h85;
  localparam logic [7:0] PVC_LIN2_RST = 8'hE8;

  // buck code-to-millivolt mapping
  localparam logic [7:0] PVC_BUCK_FINE_LAST = 8'h0F;
  localparam logic [7:0] PVC_BUCK_COARSE_FIRST = 8'h10;
  localparam logic [7:0] PVC_BUCK_MAX_CODE = 8'h1C;
  localparam logic [15:0] PVC_BUCK_FINE_BASE_MV = 16'd800;
  localparam logic [15:0] PVC_BUCK_FINE_STEP_MV = 16'd25;
  localparam logic [15:0] PVC_BUCK_COARSE_BASE_MV = 16'd1200;
  localparam logic [15:0] PVC_BUCK_COARSE_STEP_MV = 16'd50;
  localparam logic [15:0] PVC_BUCK_MAX_MV = 16'd1800;

  // linear regulator lookup: entry i gives 800 mV + i * 50 mV
  localparam logic [15:0] PVC_LIN_BASE_MV = 16'd800;
  localparam logic [15:0] PVC_LIN_STEP_MV = 16'd50;
  localparam int PVC_LIN_ENTRIES = 51;
  localparam logic [7:0] PVC_LIN_CODES [0:PVC_LIN_ENTRIES-1] = '{
    8'h00, 8'h0B, 8'h14, 8'h1D, 8'h25, 8'h2E, 8'h37, 8'h3E, 8'h45, 8'h4C,
    8'h52, 8'h57, 8'h5C, 8'h61, 8'h65, 8'h69, 8'h6D, 8'h72, 8'h79, 8'h7F,
    8'h85, 8'h8B, 8'h91, 8'h96, 8'h9A, 8'h9F, 8'hA4, 8'hA8, 8'hAC, 8'hB0,
    8'hB4, 8'hB7, 8'hBA, 8'hBD, 8'hC1, 8'hC4, 8'hC7, 8'hC9, 8'hCC, 8'hCE,
    8'hD1, 8'hD3, 8'hD6, 8'hD8, 8'hDA, 8'hDC, 8'hDE, 8'hE1, 8'hE3, 8'hE6,
    8'hE8};

  // serial clock timing: least period and its count of 50 ns cycles
  localparam int PVC_CLK_PERIOD_NS = 50;
  localparam int PVC_SCL_MIN_PERIOD_NS = 2500;
  localparam int PVC_SCL_MIN_CYCLES =
    (PVC_SCL_MIN_PERIOD_NS + PVC_CLK_PERIOD_NS - 1) / PVC_CLK_PERIOD_NS;

  // synchroniser lane positions
  localparam int PVC_IN_W = 8;
  localparam int PVC_IN_SCL = 0;
  localparam int PVC_IN_SDA = 1;
  localparam int PVC_IN_EN = 2;
  localparam int PVC_IN_UV = 3;
  localparam int PVC_IN_THERM = 4;
  localparam int PVC_IN_VALID = 5;

  // serial slave states
  typedef enum logic [3:0] {
    PVC_IDLE, PVC_ADDR, PVC_ACK_ADDR, PVC_REG, PVC_ACK_REG,
    PVC_WDATA, PVC_ACK_DATA, PVC_RDATA, PVC_RACK
  } pvc_i2c_e;

  // one register write from the serial slave
  typedef struct packed {
    logic en;
    logic [2:0] idx;
    logic [7:0] data;
  } pvc_wr_s;

endpackage

// >>> hw/pvc_lin_lut.sv
// linear regulator code-to-millivolt lookup with registered result
`timescale 1ns/100ps
`default_nettype none

module pvc_lin_lut
  import pvc_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic [7:0] code_i,
  output logic [15:0] mv_o
);

  logic [15:0] mv_r;
  logic [15:0] mv_nxt;
  logic [5:0] idx;

  // largest table entry not above the code selects the step
  always_comb begin
    idx = 6'h00;
    for (int i = 0; i < PVC_LIN_ENTRIES; i++) begin
      if (code_i >= PVC_LIN_CODES[i]) begin
        idx = 6'(i);
      end
    end
    mv_nxt = 16'(PVC_LIN_BASE_MV + PVC_LIN_STEP_MV * {10'h000, idx});
  end

  // register the target
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      mv_r <= PVC_LIN_BASE_MV;
    end else begin
      mv_r <= mv_nxt;
    end
  end

  assign mv_o = mv_r;

endmodule

`default_nettype wire

// >>> test/pvc_regs_sva.sv
// assertion checker for the voltage code register bank
`timescale 1ns/100ps
`default_nettype none

module pvc_regs_sva
  import pvc_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic scl_i,
  input wire logic sda_o,
  input wire logic sda_oe_o,
  input wire logic enable_pin_i,
  input wire logic fault_interrupt_n_o,
  input wire logic fault_interrupt_oe_o,
  input wire logic startup_pulse_o,
  input wire logic [7:0] enable_ctrl_o,
  input wire logic [15:0] buck_mv_o,
  input wire logic [15:0] linear_one_mv_o,
  input wire logic [15:0] linear_two_mv_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);

  ////////////////////////////////////////////////////////////////////////////
  // enable pin seen low then high, and the startup that must follow
  sequence s_pin_rise;
    !enable_pin_i ##1 enable_pin_i;
  endsequence
  sequence s_startup;
    startup_pulse_o && (enable_ctrl_o == PVC_EN_STARTUP);
  endsequence

  ////////////////////////////////////////////////////////////////////////////
  // startup timing and its cause
  a_startup_on_rise: assert property (
    s_pin_rise |-> ##[1:5] s_startup) else $error("no startup after rise");
  a_pulse_single: assert property (
    startup_pulse_o |=> !startup_pulse_o) else $error("startup too long");
  a_pulse_cause: assert property (
    startup_pulse_o |-> $past(enable_pin_i, 2) && !$past(enable_pin_i, 7))
    else $error("startup without pin rise");

  // pin polarity and timing of the data line
  a_sda_polarity: assert property (
    sda_o == !sda_oe_o) else $error("data out not inverse of enable");
  a_irq_open_drain: assert property (
    fault_interrupt_n_o != fault_interrupt_oe_o)
    else $error("fault pin level wrong");
  a_sda_scl_low: assert property (
    $changed(sda_oe_o) |-> !scl_i) else $error("data moved in clock high");

  // targets stay within the tabulated ranges
  a_buck_range: assert property (
    buck_mv_o >= PVC_BUCK_FINE_BASE_MV && buck_mv_o <= PVC_BUCK_MAX_MV)
    else $error("buck target out of range");
  a_lin_range: assert property (
    linear_one_mv_o >= PVC_LIN_BASE_MV && linear_one_mv_o <= 16'hCE4 &&
    linear_two_mv_o >= PVC_LIN_BASE_MV && linear_two_mv_o <= 16'hCE4)
    else $error("linear target out of range");
endmodule

bind pvc_regs pvc_regs_sva u_sva (
  .clk_i(clk_i), .rst_n_i(rst_n_i), .scl_i(scl_i), .sda_o(sda_o),
  .sda_oe_o(sda_oe_o), .enable_pin_i(enable_pin_i),
  .fault_interrupt_n_o(fault_interrupt_n_o),
  .fault_interrupt_oe_o(fault_interrupt_oe_o),
  .startup_pulse_o(startup_pulse_o), .enable_ctrl_o(enable_ctrl_o),
  .buck_mv_o(buck_mv_o), .linear_one_mv_o(linear_one_mv_o),
  .linear_two_mv_o(linear_two_mv_o)
);

`default_nettype wire

// >>> test/pvc_host_model.sv
// serial bus master model that drives the clock and pulls the data line
`timescale 1ns/100ps
`default_nettype none

module pvc_host_model (
  input wire logic clk_i,
  input wire logic sda_i,
  output logic scl_o,
  output logic sda_low_o
);
  // period of 52 cycles, above 2.5 us
  localparam int QTR = 13;

  // lines released at start
  initial begin
    scl_o = 1'b1;
    sda_low_o = 1'b0;
  end

  task automatic wait_q();
    repeat (QTR) @(negedge clk_i);
  endtask

  // one bit: data set in clock low, sampled mid high phase
  task automatic bit_x(input logic b, output logic r);
    sda_low_o = !b;
    wait_q();
    scl_o = 1'b1;
    wait_q();
    r = sda_i;
    wait_q();
    scl_o = 1'b0;
    wait_q();
  endtask

  // start or repeated start: data falls while clock high
  task automatic start();
    sda_low_o = 1'b0;
    wait_q();
    scl_o = 1'b1;
    wait_q();
    sda_low_o = 1'b1;
    wait_q();
    scl_o = 1'b0;
    wait_q();
  endtask

  // stop: data rises while clock high, then the bus rests
  task automatic stop();
    sda_low_o = 1'b1;
    wait_q();
    scl_o = 1'b1;
    wait_q();
    sda_low_o = 1'b0;
    wait_q();
  endtask

  // byte msb first, ninth bit acknowledge
  task automatic xfer(input logic [7:0] tx, input logic last,
                      output logic [7:0] rx, output logic ack_n);
    for (int i = 7; i >= 0; i--) begin
      bit_x(tx[i], rx[i]);
    end
    bit_x(last, ack_n);
  endtask
endmodule

`default_nettype wire

// >>> test/pvc_regs_tb_top.sv
// self-checking bench for the voltage code register bank
`timescale 1ns/100ps
`default_nettype none

module pvc_regs_tb_top
  import pvc_pkg::*;
;
  // only tabulated buck codes, boundaries included
  localparam logic [7:0] BC [0:10] = '{8'h00, 8'h01, 8'h07, 8'h0E,
    8'h0F, 8'h10, 8'h11, 8'h15, 8'h1A, 8'h1B, 8'h1C};
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic enable_pin = 1'b0;
  logic input_undervoltage_flag = 1'b0;
  logic thermal_shutdown_flag = 1'b0;
  logic [2:0] rail_valid = 3'h5;
  logic scl, host_low, sda_out, sda_oe, irq_n, irq_oe, pulse;
  logic [7:0] en_ctrl;
  logic [15:0] buck_mv, lin1_mv, lin2_mv;
  wire sda_w;
  int fail_count = 0;
  int comparisons = 0;
  int cyc = 0;
  int pulses = 0;

  // open-drain data line with pull-up
  assign sda_w = !(host_low || sda_oe);
  always #25 clk = ~clk;

  pvc_regs DUT (
    .clk_i(clk), .rst_n_i(rst_n), .scl_i(scl), .sda_i(sda_w),
    .sda_o(sda_out), .sda_oe_o(sda_oe), .enable_pin_i(enable_pin),
    .input_undervoltage_flag_i(input_undervoltage_flag),
    .thermal_shutdown_flag_i(thermal_shutdown_flag),
    .rail_valid_i(rail_valid), .fault_interrupt_n_o(irq_n),
    .fault_interrupt_oe_o(irq_oe), .startup_pulse_o(pulse),
    .enable_ctrl_o(en_ctrl), .buck_mv_o(buck_mv),
    .linear_one_mv_o(lin1_mv), .linear_two_mv_o(lin2_mv));
  pvc_host_model u_host (.clk_i(clk), .sda_i(sda_w), .scl_o(scl),
    .sda_low_o(host_low));

  ////////////////////////////////////////////////////////////////////////////
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  task automatic chk(input string what, input logic [15:0] seen,
                     input logic [15:0] exp);
    comparisons++;
    if (seen !== exp) begin
      fail_count++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // start, device address for write, register byte
  task automatic head(input logic [7:0] r);
    logic [7:0] rx;
    logic a;
    u_host.start();
    u_host.xfer({PVC_DEV_ADDR, 1'b0}, 1'b1, rx, a);
    chk("addr ack", 16'(a), 16'h0000);
    u_host.xfer(r, 1'b1, rx, a);
  endtask

  task automatic reg_wr(input logic [7:0] r, input logic [23:0] d,
                        input int n);
    logic [7:0] rx;
    logic a;
    head(r);
    for (int j = 0; j < n; j++) begin
      u_host.xfer(d[23-8*j -: 8], 1'b1, rx, a);
      chk("data ack", 16'(a), 16'h0000);
    end
    u_host.stop();
  endtask

  task automatic rd_chk(input string what, input logic [7:0] r,
                        input logic [7:0] exp);
    logic [7:0] v;
    logic a;
    head(r);
    u_host.start();
    u_host.xfer({PVC_DEV_ADDR, 1'b1}, 1'b1, v, a);
    u_host.xfer(8'hFF, 1'b1, v, a);
    u_host.stop();
    chk(what, 16'(v), 16'(exp));
  endtask

  function automatic logic [15:0] buck_exp(input logic [7:0] c);
    if (c <= PVC_BUCK_FINE_LAST)
      return PVC_BUCK_FINE_BASE_MV + 16'(c) * PVC_BUCK_FINE_STEP_MV;
    return PVC_BUCK_COARSE_BASE_MV +
      16'(c - PVC_BUCK_COARSE_FIRST) * PVC_BUCK_COARSE_STEP_MV;
  endfunction

  function automatic logic [15:0] lin_exp(input int k);
    return PVC_LIN_BASE_MV + 16'(k) * PVC_LIN_STEP_MV;
  endfunction

  // startup pulse counter and run limit
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (pulse === 1'b1) pulses <= pulses + 1;
    if (cyc == 90000) begin
      fail_count++;
      print_verdict();
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    logic [7:0] rx;
    logic a;
    repeat (10) @(negedge clk);
    rst_n = 1'b1;
    repeat (4) @(negedge clk);
    chk("en por", 16'(en_ctrl), 16'(PVC_EN_POR));
    chk("lin1 rst", lin1_mv, lin_exp(20));
    $display("test reset done");
    for (int i = 0; i <= 10; i++) begin
      reg_wr(8'h02, {BC[i], PVC_LIN_CODES[5*i], PVC_LIN_CODES[50-5*i]},
             3);
      chk("buck mv", buck_mv, buck_exp(BC[i]));
      chk("lin1 mv", lin1_mv, lin_exp(5*i));
      chk("lin2 mv", lin2_mv, lin_exp(50-5*i));
    end
    rd_chk("buck code", 8'hFA, 8'h1C);
    rd_chk("lin2 code", 8'h04, 8'h00);
    // two-byte read from the buck index, master acks the first byte
    head(8'h02);
    u_host.start();
    u_host.xfer({PVC_DEV_ADDR, 1'b1}, 1'b1, rx, a);
    chk("rd ack", 16'(a), 16'h0000);
    u_host.xfer(8'hFF, 1'b0, rx, a);
    chk("rd first", 16'(rx), 16'h001C);
    u_host.xfer(8'hFF, 1'b1, rx, a);
    u_host.stop();
    chk("rd next", 16'(rx), 16'(PVC_LIN_CODES[50]));
    reg_wr(8'hFB, {8'h45, 16'h0000}, 1);
    chk("lin1 hi addr", lin1_mv, lin_exp(8));
    reg_wr(8'h05, {8'hAA, 16'h0000}, 1);
    rd_chk("spare", 8'h05, 8'h00);
    u_host.start();
    u_host.xfer({PVC_DEV_ADDR ^ 7'h01, 1'b0}, 1'b1, rx, a);
    chk("foreign ack", 16'(a), 16'h0001);
    u_host.xfer(8'h02, 1'b1, rx, a);
    u_host.xfer(8'h00, 1'b1, rx, a);
    u_host.stop();
    chk("buck kept", buck_mv, buck_exp(8'h1C));
    $display("test codes done");
    reg_wr(8'h00, {8'h00, 16'h0000}, 1);
    chk("en off", 16'(en_ctrl), 16'h0000);
    enable_pin = 1'b1;
    repeat (6) @(negedge clk);
    chk("en start", 16'(en_ctrl), 16'(PVC_EN_STARTUP));
    reg_wr(8'h00, {8'h00, 16'h0000}, 1);
    repeat (200) @(negedge clk);
    chk("en held", 16'(en_ctrl), 16'h0000);
    chk("pulses", 16'(pulses), 16'h0001);
    enable_pin = 1'b0;
    $display("test enable done");
    input_undervoltage_flag = 1'b1;
    repeat (8) @(negedge clk);
    chk("irq gated", 16'(irq_oe), 16'h0000);
    input_undervoltage_flag = 1'b0;
    rd_chk("status uv", 8'h01, 8'h25);
    reg_wr(8'h01, {8'h70, 16'h0000}, 1);
    chk("irq clear", 16'(irq_oe), 16'h0000);
    thermal_shutdown_flag = 1'b1;
    repeat (4) @(negedge clk);
    chk("irq set", 16'({irq_oe, irq_n}), 16'h0002);
    rd_chk("status therm", 8'h01, 8'h55);
    thermal_shutdown_flag = 1'b0;
    reg_wr(8'h01, {8'h50, 16'h0000}, 1);
    chk("irq echo", 16'(irq_oe), 16'h0000);
    $display("test fault done");
    print_verdict();
  end
endmodule

`default_nettype wire
